// ==== shared/nrd_pkg.sv ====
// constants shared by the nmi and reset distribution block
package nrd_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_PRI_NMI_FLAGS       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRI_NMI_FLAG_CLEAR  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PRI_NMI_FLAG_FORCE  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PRI_NMI_WDOG        = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CTL_NMI_FLAGS       = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CTL_NMI_FLAG_CLEAR  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CTL_NMI_FLAG_FORCE  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CTL_NMI_WDOG        = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_REMOTE_RESET_CTRL   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_REMOTE_RESET_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_PERIPH_RESET_CTRL   = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_DEVICE_CONFIG       = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE         = 8'h30;

  // nmi source positions, primary block
  localparam int PSRC_CTL_WDOG    = 0;
  localparam int PSRC_VEC_FETCH   = 1;
  localparam int PSRC_OSC_MISSING = 2;
  localparam int PSRC_ABUS_ERR    = 3;
  localparam int PSRC_EXT_EMERG   = 4;
  localparam int PSRC_PRI_BIST    = 5;
  localparam int PSRC_CTL_BIST    = 6;
  // nmi source positions, control block
  localparam int CSRC_OSC_MISSING = 0;
  localparam int CSRC_ABUS_ERR    = 1;
  localparam int CSRC_RAM_UNC     = 2;
  localparam int CSRC_FLASH_UNC   = 3;
  localparam int CSRC_VEC_FETCH   = 4;
  localparam int CSRC_CTL_BIST    = 5;
  localparam int CSRC_PRI_BIST    = 6;

  localparam int NMI_SRC_W = 7;
  localparam int NMI_CNT_W = 16;
  localparam logic [NMI_CNT_W-1:0] NMI_WDOG_LIMIT = 16'h0400;
  localparam int WDOG_RUN_BIT  = 16;
  localparam int WDOG_EXP_BIT  = 17;
  localparam int WDOG_STOP_BIT = 0;

  localparam int RRC_CTL_REQ  = 0;
  localparam int RRC_ABUS_RST = 1;
  localparam int RRS_SEEN     = 0;

  localparam int CAUSE_W    = 5;
  localparam int CAUSE_EXT  = 0;
  localparam int CAUSE_POR  = 1;
  localparam int CAUSE_WD0  = 2;
  localparam int CAUSE_WD1  = 3;
  localparam int CAUSE_SW   = 4;

  localparam int PULSE_CNT_W = 8;
  localparam logic [PULSE_CNT_W-1:0] PIN_PULSE_CYCLES = 8'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== shared/nrd_nmi_if.sv ====
// carrier between the top and one nmi collection unit
`timescale 1ns/1ps
`default_nettype none
interface nrd_nmi_if #(parameter int NSRC = 7, parameter int CW = 16);
  logic [NSRC-1:0] src;
  logic            sub_reset;
  logic [NSRC-1:0] clr_bits;
  logic [NSRC-1:0] frc_bits;
  logic            wd_stop;
  logic [NSRC-1:0] flags;
  logic            irq;
  logic            event_p;
  logic            wd_reset;
  logic            wd_running;
  logic [CW-1:0]   wd_count;
  modport unit (input src, sub_reset, clr_bits, frc_bits, wd_stop,
                output flags, irq, event_p, wd_reset, wd_running, wd_count);
  modport ctrl (output src, sub_reset, clr_bits, frc_bits, wd_stop,
                input flags, irq, event_p, wd_reset, wd_running, wd_count);
endinterface
`default_nettype wire

// ==== design/nrd_nmi_unit.sv ====
// nmi flag collection with its nmi watchdog
`timescale 1ns/1ps
`default_nettype none
module nrd_nmi_unit
  import nrd_pkg::*;
#(
  parameter logic [NMI_CNT_W-1:0] LIMIT = NMI_WDOG_LIMIT
) (
  input wire logic ref_clk,
  input wire logic resetn,
  nrd_nmi_if.unit  nmi
);

  typedef struct packed {
    logic [NMI_SRC_W-1:0] flags;
    logic                 evt;
    logic                 run;
    logic                 expired;
    logic [NMI_CNT_W-1:0] cnt;
  } nrd_unit_state_type;

  nrd_unit_state_type q;
  nrd_unit_state_type d;

  always_comb begin
    d = q;
    d.flags = (q.flags & ~nmi.clr_bits) | nmi.src | nmi.frc_bits;
    d.evt = |(d.flags & ~q.flags);
    if (nmi.wd_stop) begin
      d.run = 1'b0;
      d.cnt = '0;
    end else if (q.run) begin
      if (q.cnt == LIMIT - 1'b1) begin
        d.run     = 1'b0;
        d.expired = 1'b1;
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end
    if (d.evt && !q.run && !q.expired) begin
      d.run = 1'b1;
      d.cnt = '0;
    end
    if (nmi.sub_reset) begin
      d = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign nmi.flags      = q.flags;
  assign nmi.irq        = |q.flags;
  assign nmi.event_p    = q.evt;
  assign nmi.wd_reset   = q.expired;
  assign nmi.wd_running = q.run;
  assign nmi.wd_count   = q.cnt;

endmodule
`default_nettype wire

// ==== design/nrd_pulse_stretch.sv ====
// stretches a reset trigger into a pin drive pulse
`timescale 1ns/1ps
`default_nettype none
module nrd_pulse_stretch
  import nrd_pkg::*;
#(
  parameter logic [PULSE_CNT_W-1:0] LEN = PIN_PULSE_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic trig,
  output var  logic active
);

  typedef struct packed {
    logic                   act;
    logic [PULSE_CNT_W-1:0] cnt;
  } nrd_stretch_state_type;

  nrd_stretch_state_type q;
  nrd_stretch_state_type d;

  always_comb begin
    d = q;
    if (trig) begin
      d.cnt = LEN;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end
    d.act = (d.cnt != '0);
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign active = q.act;

endmodule
`default_nettype wire

// ==== design/nrd_top.sv ====
// nmi collection and reset distribution with an axi4-lite register slave
//
// Summary of operation
// - any primary nmi source raises primary interrupt and watchdog start event
// - primary nmi watchdog not stopped counts to limit then requests reset
// - software stopping the primary nmi watchdog prevents its reset
// - primary block takes six listed error sources and control nmi watchdog expiry as its seven nmi inputs
// - primary block has flag, clear and force registers
// - any control nmi source raises control interrupt and watchdog event
// - control nmi watchdog expiry resets control side and flags primary nmi
// - control block takes seven listed error sources as nmi inputs
// - control block has flag, clear and force registers
// - low system reset pin resets primary and control subsystems
// - pin driven low on power-on or any primary watchdog expiry
// - analog pin resets analog side; analog power-on drives that pin
// - primary cpu reset is power-on or primary system reset
// - primary system reset ORs pin, watchdog, software and debugger resets
// - primary watchdog reset ORs both watchdogs and primary nmi watchdog
// - software and debugger resets also reset control and analog sides
// - remote control bits reset control subsystem and analog interface bus
// - status bit shows control system reset happened
// - peripheral reset bits act only on peripherals enabled in device config
// - reset cause records pin, power-on, watchdog 0, watchdog 1, software
// - control cpu reset ORs pin, control nmi wdog, sw, dbg, request
`timescale 1ns/1ps
`default_nettype none
module nrd_top
  import nrd_pkg::*;
#(
  parameter logic [NMI_CNT_W-1:0]   PRI_WDOG_LIMIT = NMI_WDOG_LIMIT,
  parameter logic [NMI_CNT_W-1:0]   CTL_WDOG_LIMIT = NMI_WDOG_LIMIT,
  parameter logic [PULSE_CNT_W-1:0] PIN_PULSE      = PIN_PULSE_CYCLES
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [DATA_W-1:0] s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // error sources
  input  wire logic              vector_fetch_error,
  input  wire logic              osc_clock_missing,
  input  wire logic              analog_bus_error,
  input  wire logic              external_emergency,
  input  wire logic              primary_selftest_error,
  input  wire logic              control_selftest_error,
  input  wire logic              ram_uncorrectable,
  input  wire logic              flash_uncorrectable,
  // reset sources
  input  wire logic              power_on_reset,
  input  wire logic              analog_power_on_reset,
  input  wire logic              primary_wdog0_timeout,
  input  wire logic              primary_wdog1_timeout,
  input  wire logic              software_reset,
  input  wire logic              debugger_reset,
  input  wire logic              control_system_reset,
  input  wire logic [DATA_W-1:0] device_config,
  // open-drain pins
  input  wire logic              system_reset_pin_in,
  output var  logic              system_reset_pin_out,
  output var  logic              system_reset_pin_oe,
  input  wire logic              analog_reset_pin_in,
  output var  logic              analog_reset_pin_out,
  output var  logic              analog_reset_pin_oe,
  // nmi outputs
  output var  logic              primary_nmi_interrupt,
  output var  logic              primary_nmi_event,
  output var  logic              primary_nmi_wdog_reset,
  output var  logic              control_nmi_interrupt,
  output var  logic              control_nmi_event,
  output var  logic              control_nmi_wdog_reset,
  // reset outputs
  output var  logic              primary_watchdog_reset,
  output var  logic              primary_system_reset,
  output var  logic              primary_cpu_reset,
  output var  logic              control_cpu_reset_in,
  output var  logic              analog_subsys_reset,
  output var  logic              analog_bus_reset,
  output var  logic [DATA_W-1:0] peripheral_reset
);

  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic                 aw_have;
    logic [ADDR_W-1:0]    aw_addr;
    logic                 w_have;
    logic [DATA_W-1:0]    w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [DATA_W-1:0]    rdata;
    logic [1:0]           rresp;
    logic [1:0]           remote_ctrl;
    logic                 ctl_seen;
    logic [DATA_W-1:0]    periph_ctrl;
    logic [CAUSE_W-1:0]   cause;
    logic                 pnmi_irq;
    logic                 pnmi_evt;
    logic                 pnmi_wd;
    logic                 cnmi_irq;
    logic                 cnmi_evt;
    logic                 cnmi_wd;
    logic                 pwdog_rst;
    logic                 psys_rst;
    logic                 pcpu_rst;
    logic                 ccpu_rst;
    logic                 ana_rst;
    logic [DATA_W-1:0]    periph_rst;
    logic                 xpin_oe;
    logic                 apin_oe;
  } nrd_top_state_type;

  nrd_top_state_type q;
  nrd_top_state_type d;

  nrd_nmi_if #(.NSRC(NMI_SRC_W), .CW(NMI_CNT_W)) pri_nmi ();
  nrd_nmi_if #(.NSRC(NMI_SRC_W), .CW(NMI_CNT_W)) ctl_nmi ();

  logic              wr_go;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] wbits;
  logic              wr_hit;
  logic              pin_xrs_low;
  logic              pin_ars_low;
  logic              xpin_drive;
  logic              apin_drive;
  logic [DATA_W-1:0] rd_val;
  logic              rd_hit;

  assign pri_nmi.src[PSRC_CTL_WDOG]    = ctl_nmi.wd_reset;
  assign pri_nmi.src[PSRC_VEC_FETCH]   = vector_fetch_error;
  assign pri_nmi.src[PSRC_OSC_MISSING] = osc_clock_missing;
  assign pri_nmi.src[PSRC_ABUS_ERR]    = analog_bus_error;
  assign pri_nmi.src[PSRC_EXT_EMERG]   = external_emergency;
  assign pri_nmi.src[PSRC_PRI_BIST]    = primary_selftest_error;
  assign pri_nmi.src[PSRC_CTL_BIST]    = control_selftest_error;
  assign ctl_nmi.src[CSRC_OSC_MISSING] = osc_clock_missing;
  assign ctl_nmi.src[CSRC_ABUS_ERR]    = analog_bus_error;
  assign ctl_nmi.src[CSRC_RAM_UNC]     = ram_uncorrectable;
  assign ctl_nmi.src[CSRC_FLASH_UNC]   = flash_uncorrectable;
  assign ctl_nmi.src[CSRC_VEC_FETCH]   = vector_fetch_error;
  assign ctl_nmi.src[CSRC_CTL_BIST]    = control_selftest_error;
  assign ctl_nmi.src[CSRC_PRI_BIST]    = primary_selftest_error;

  // flags are wiped by the reset of the subsystem that owns them
  assign pri_nmi.sub_reset = q.psys_rst;
  assign ctl_nmi.sub_reset = q.ccpu_rst;

  assign pin_xrs_low = !system_reset_pin_in;
  assign pin_ars_low = !analog_reset_pin_in;
  assign wr_go       = q.aw_have && q.w_have && !q.bvalid;
  assign wmask       = {{8{q.w_strb[3]}}, {8{q.w_strb[2]}}, {8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
  assign wbits       = q.w_data & wmask;

  assign pri_nmi.clr_bits = (wr_go && q.aw_addr == OFS_PRI_NMI_FLAG_CLEAR) ?
                            wbits[NMI_SRC_W-1:0] : '0;
  assign pri_nmi.frc_bits = (wr_go && q.aw_addr == OFS_PRI_NMI_FLAG_FORCE) ?
                            wbits[NMI_SRC_W-1:0] : '0;
  assign ctl_nmi.clr_bits = (wr_go && q.aw_addr == OFS_CTL_NMI_FLAG_CLEAR) ?
                            wbits[NMI_SRC_W-1:0] : '0;
  assign ctl_nmi.frc_bits = (wr_go && q.aw_addr == OFS_CTL_NMI_FLAG_FORCE) ?
                            wbits[NMI_SRC_W-1:0] : '0;
  assign pri_nmi.wd_stop  = wr_go && q.aw_addr == OFS_PRI_NMI_WDOG && wbits[WDOG_STOP_BIT];
  assign ctl_nmi.wd_stop  = wr_go && q.aw_addr == OFS_CTL_NMI_WDOG && wbits[WDOG_STOP_BIT];

  nrd_nmi_unit #(.LIMIT(PRI_WDOG_LIMIT)) u_pri_nmi (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .nmi     (pri_nmi)
  );

  nrd_nmi_unit #(.LIMIT(CTL_WDOG_LIMIT)) u_ctl_nmi (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .nmi     (ctl_nmi)
  );

  // pin pulse on power-on or primary watchdog expiry
  nrd_pulse_stretch #(.LEN(PIN_PULSE)) u_xrs_drive (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .trig    (power_on_reset | primary_wdog0_timeout | primary_wdog1_timeout |
              pri_nmi.wd_reset),
    .active  (xpin_drive)
  );

  // analog power-on drives the analog pin
  nrd_pulse_stretch #(.LEN(PIN_PULSE)) u_ars_drive (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .trig    (analog_power_on_reset),
    .active  (apin_drive)
  );

  // register read decode
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr == OFS_PRI_NMI_FLAGS) begin
      rd_val[NMI_SRC_W-1:0] = pri_nmi.flags;
    end else if (s_axi_araddr == OFS_PRI_NMI_WDOG) begin
      rd_val[NMI_CNT_W-1:0] = pri_nmi.wd_count;
      rd_val[WDOG_RUN_BIT]  = pri_nmi.wd_running;
      rd_val[WDOG_EXP_BIT]  = pri_nmi.wd_reset;
    end else if (s_axi_araddr == OFS_CTL_NMI_FLAGS) begin
      rd_val[NMI_SRC_W-1:0] = ctl_nmi.flags;
    end else if (s_axi_araddr == OFS_CTL_NMI_WDOG) begin
      rd_val[NMI_CNT_W-1:0] = ctl_nmi.wd_count;
      rd_val[WDOG_RUN_BIT]  = ctl_nmi.wd_running;
      rd_val[WDOG_EXP_BIT]  = ctl_nmi.wd_reset;
    end else if (s_axi_araddr inside {OFS_PRI_NMI_FLAG_CLEAR, OFS_PRI_NMI_FLAG_FORCE,
                                      OFS_CTL_NMI_FLAG_CLEAR, OFS_CTL_NMI_FLAG_FORCE}) begin
      rd_val = '0;
    end else if (s_axi_araddr == OFS_REMOTE_RESET_CTRL) begin
      rd_val[1:0] = q.remote_ctrl;
    end else if (s_axi_araddr == OFS_REMOTE_RESET_STATUS) begin
      rd_val[RRS_SEEN] = q.ctl_seen;
    end else if (s_axi_araddr == OFS_PERIPH_RESET_CTRL) begin
      rd_val = q.periph_ctrl;
    end else if (s_axi_araddr == OFS_DEVICE_CONFIG) begin
      rd_val = device_config;
    end else if (s_axi_araddr == OFS_RESET_CAUSE) begin
      rd_val[CAUSE_W-1:0] = q.cause;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // write address hit check, same map as reads
  always_comb begin
    wr_hit = 1'b1;
    if (q.aw_addr == OFS_DEVICE_CONFIG || q.aw_addr == OFS_PRI_NMI_FLAGS ||
        q.aw_addr == OFS_CTL_NMI_FLAGS) begin
      wr_hit = 1'b1;
    end else if (q.aw_addr > OFS_RESET_CAUSE || q.aw_addr[1:0] != 2'h0) begin
      wr_hit = 1'b0;
    end
  end

  always_comb begin
    d = q;
    // write channels are taken in either order and held until both arrive
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (q.aw_addr == OFS_REMOTE_RESET_CTRL) begin
        d.remote_ctrl = (q.remote_ctrl & ~wmask[1:0]) | wbits[1:0];
      end else if (q.aw_addr == OFS_PERIPH_RESET_CTRL) begin
        d.periph_ctrl = (q.periph_ctrl & ~wmask) | wbits;
      end else if (q.aw_addr == OFS_REMOTE_RESET_STATUS) begin
        d.ctl_seen = q.ctl_seen & ~wbits[RRS_SEEN];
      end else if (q.aw_addr == OFS_RESET_CAUSE) begin
        d.cause = q.cause & ~wbits[CAUSE_W-1:0];
      end
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;

    // one read in flight; data are captured with the address
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_val;
      d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    d.arready = !d.rvalid;

    if (control_system_reset) begin
      d.ctl_seen = 1'b1;
    end
    // reset cause, each event beats a clear
    if (pin_xrs_low && !q.xpin_oe) begin
      d.cause[CAUSE_EXT] = 1'b1;
    end
    if (power_on_reset) begin
      d.cause[CAUSE_POR] = 1'b1;
    end
    if (primary_wdog0_timeout) begin
      d.cause[CAUSE_WD0] = 1'b1;
    end
    if (primary_wdog1_timeout) begin
      d.cause[CAUSE_WD1] = 1'b1;
    end
    if (software_reset) begin
      d.cause[CAUSE_SW] = 1'b1;
    end

    // interrupt and event to each cpu and watchdog
    d.pnmi_irq = pri_nmi.irq;
    d.pnmi_evt = pri_nmi.event_p;
    d.cnmi_irq = ctl_nmi.irq;
    d.cnmi_evt = ctl_nmi.event_p;
    d.pnmi_wd  = pri_nmi.wd_reset;
    d.cnmi_wd  = ctl_nmi.wd_reset;

    d.pwdog_rst = primary_wdog0_timeout | primary_wdog1_timeout | pri_nmi.wd_reset;
    d.psys_rst  = pin_xrs_low | d.pwdog_rst | software_reset | debugger_reset;
    d.pcpu_rst  = power_on_reset | d.psys_rst;
    d.ccpu_rst  = pin_xrs_low | ctl_nmi.wd_reset | software_reset | debugger_reset |
                  q.remote_ctrl[RRC_CTL_REQ];
    d.ana_rst   = pin_ars_low | software_reset | debugger_reset;
    d.periph_rst = q.periph_ctrl & device_config;
    // open-drain drive, enable high while pulling low
    d.xpin_oe = xpin_drive;
    d.apin_oe = apin_drive;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready          = q.awready;
  assign s_axi_wready           = q.wready;
  assign s_axi_bresp            = q.bresp;
  assign s_axi_bvalid           = q.bvalid;
  assign s_axi_arready          = q.arready;
  assign s_axi_rdata            = q.rdata;
  assign s_axi_rresp            = q.rresp;
  assign s_axi_rvalid           = q.rvalid;
  // open-drain pins only ever pull low
  assign system_reset_pin_out   = 1'b0;
  assign analog_reset_pin_out   = 1'b0;
  assign system_reset_pin_oe    = q.xpin_oe;
  assign analog_reset_pin_oe    = q.apin_oe;
  assign primary_nmi_interrupt  = q.pnmi_irq;
  assign primary_nmi_event      = q.pnmi_evt;
  assign primary_nmi_wdog_reset = q.pnmi_wd;
  assign control_nmi_interrupt  = q.cnmi_irq;
  assign control_nmi_event      = q.cnmi_evt;
  assign control_nmi_wdog_reset = q.cnmi_wd;
  assign primary_watchdog_reset = q.pwdog_rst;
  assign primary_system_reset   = q.psys_rst;
  assign primary_cpu_reset      = q.pcpu_rst;
  assign control_cpu_reset_in   = q.ccpu_rst;
  assign analog_subsys_reset    = q.ana_rst;
  // analog interface bus reset held while the bit is set
  assign analog_bus_reset       = q.remote_ctrl[RRC_ABUS_RST];
  assign peripheral_reset       = q.periph_rst;

endmodule
`default_nettype wire

// ==== testbench/nrd_pin_model.sv ====
// board side of an open-drain reset pin with its pull-up
`timescale 1ns/1ps
`default_nettype none
module nrd_pin_model (
  input  wire logic oe,
  input  wire logic ext_low,
  output var  logic pin
);
  always_comb pin = !(oe || ext_low);
endmodule
`default_nettype wire

// ==== testbench/nrd_properties.sv ====
// timing checks on the nmi and reset outputs of the top block
`timescale 1ns/1ps
`default_nettype none
module nrd_properties (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic external_emergency,
  input wire logic primary_nmi_interrupt,
  input wire logic primary_nmi_wdog_reset,
  input wire logic primary_system_reset,
  input wire logic primary_cpu_reset,
  input wire logic control_cpu_reset_in,
  input wire logic software_reset,
  input wire logic power_on_reset,
  input wire logic primary_wdog0_timeout,
  input wire logic primary_watchdog_reset,
  input wire logic system_reset_pin_in,
  input wire logic system_reset_pin_oe
);
  logic run_q;
  always_ff @(posedge ref_clk) run_q <= resetn;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn || !run_q);
  pri_irq_a: assert property (external_emergency |-> ##2 primary_nmi_interrupt)
    else $error("nmi interrupt late");
  nmi_expiry_a: assert property (
    $rose(primary_nmi_wdog_reset) |-> ##[1:2] primary_system_reset)
    else $error("nmi watchdog reset lost");
  pin_in_a: assert property (
    !system_reset_pin_in |=> primary_system_reset && control_cpu_reset_in)
    else $error("pin reset lost");
  pin_drive_a: assert property (power_on_reset |-> ##2 system_reset_pin_oe)
    else $error("pin idle");
  cpu_por_a: assert property (power_on_reset |=> primary_cpu_reset)
    else $error("cpu reset");
  sys_or_a: assert property (software_reset |=> primary_system_reset)
    else $error("sys reset");
  wdog_or_a: assert property (primary_wdog0_timeout |=> primary_watchdog_reset)
    else $error("wd");
  ctl_sw_a: assert property (software_reset |=> control_cpu_reset_in)
    else $error("ctl reset");
  cover property (primary_nmi_wdog_reset);
  cover property (power_on_reset);
  cover property (external_emergency);
endmodule
bind nrd_top nrd_properties nrd_properties_inst (.*);
`default_nettype wire

// ==== testbench/tb_nrd_top.sv ====
// self-checking bench for the nmi and reset distribution block
`timescale 1ns/1ps
`default_nettype none
module tb_nrd_top;
  import nrd_pkg::*;
  logic ref_clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, peripheral_reset;
  logic system_reset_pin_in, analog_reset_pin_in, primary_nmi_interrupt, primary_nmi_wdog_reset;
  logic control_nmi_interrupt, primary_watchdog_reset, primary_system_reset, primary_cpu_reset;
  logic control_cpu_reset_in, analog_subsys_reset, analog_bus_reset, system_reset_pin_oe;
  logic analog_reset_pin_oe, resetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, board_low = '1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, es = '0;
  logic [6:0] rs = '0;
  logic [31:0] s_axi_wdata = '0, device_config = '0;
  int err_count = 0, tests_run = 0, cyc = 0;
  nrd_top #(.PRI_WDOG_LIMIT(16'h0020), .CTL_WDOG_LIMIT(16'h0020), .PIN_PULSE(8'h04)) nrd_top_inst (
    .*, .s_axi_wstrb(4'hF), .system_reset_pin_out(), .analog_reset_pin_out(), .primary_nmi_event(),
    .control_nmi_event(), .control_nmi_wdog_reset(), .vector_fetch_error(es[7]),
    .osc_clock_missing(es[6]), .analog_bus_error(es[5]), .primary_selftest_error(es[4]),
    .control_selftest_error(es[3]), .ram_uncorrectable(es[2]), .flash_uncorrectable(es[1]),
    .external_emergency(es[0]), .power_on_reset(rs[6]), .analog_power_on_reset(rs[5]),
    .primary_wdog0_timeout(rs[4]), .primary_wdog1_timeout(rs[3]), .software_reset(rs[2]),
    .debugger_reset(rs[1]), .control_system_reset(rs[0]));
  nrd_pin_model sys_pin_inst (.oe(system_reset_pin_oe), .ext_low(board_low),
    .pin(system_reset_pin_in));
  nrd_pin_model ana_pin_inst (.oe(analog_reset_pin_oe), .ext_low(board_low),
    .pin(analog_reset_pin_in));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    fork
      begin do @(posedge ref_clk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge ref_clk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    @(posedge ref_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    if (r === RESP_OKAY) chk("rdata", e, s_axi_rdata);
  endtask
  task automatic s_nmi_all();
    @(posedge ref_clk);
    es <= 8'hFF;
    @(posedge ref_clk);
    es <= 8'h00;
    wr(8'h0C, 32'h1);
    wr(8'h1C, 32'h1);
    chk("irq", 32'h3, {30'h0, primary_nmi_interrupt, control_nmi_interrupt});
    rd(8'h00, 32'h7E);
    rd(8'h10, 32'h7F);
    wr(8'h04, 32'h2);
    rd(8'h00, 32'h7C);
    wr(8'h04, 32'h7C);
    wr(8'h14, 32'h7F);
    rd(8'h10, 32'h0);
  endtask
  task automatic s_wdog();
    @(posedge ref_clk);
    es <= 8'h01;
    @(posedge ref_clk);
    es <= 8'h00;
    wr(8'h0C, 32'h1);
    repeat (48) @(posedge ref_clk);
    chk("wdog held", 32'h1, {30'h0, primary_nmi_wdog_reset, primary_nmi_interrupt});
    wr(8'h04, 32'h10);
    wr(8'h08, 32'h10);
    rd(8'h00, 32'h10);
    repeat (80) if (primary_nmi_wdog_reset !== 1'b1) @(posedge ref_clk);
    chk("wdog expiry", 32'h1, {31'h0, primary_nmi_wdog_reset});
    repeat (40) @(posedge ref_clk);
    wr(8'h18, 32'h1);
    repeat (40) @(posedge ref_clk);
    rd(8'h00, 32'h1);
    wr(8'h0C, 32'h1);
  endtask
  task automatic s_regs();
    wr(8'h20, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk("remote", 32'h3, {30'h0, control_cpu_reset_in, analog_bus_reset});
    wr(8'h20, 32'h0);
    device_config <= 32'h0000FF00;
    wr(8'h28, 32'hFFFFFFFF);
    repeat (2) @(posedge ref_clk);
    chk("periph", 32'h0000FF00, peripheral_reset);
    rd(8'h2C, 32'h0000FF00);
    rd(8'h40, 32'h0, RESP_SLVERR);
  endtask
  task automatic s_resets();
    @(posedge ref_clk);
    rs <= 7'h7F;
    @(posedge ref_clk);
    rs <= 7'h00;
    @(posedge ref_clk);
    chk("resets", 32'h1F, {primary_system_reset, primary_cpu_reset, control_cpu_reset_in,
        analog_subsys_reset, primary_watchdog_reset});
    @(posedge ref_clk);
    chk("pin drive", 32'h3, {30'h0, system_reset_pin_oe, analog_reset_pin_oe});
    repeat (40) @(posedge ref_clk);
    rd(8'h24, 32'h1);
    rd(8'h30, 32'h1F);
    wr(8'h30, 32'h1F);
    rd(8'h30, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    board_low <= 1'b0;
    repeat (10) @(posedge ref_clk);
    s_nmi_all();
    s_wdog();
    s_regs();
    s_resets();
    stop_test();
  end
endmodule
`default_nettype wire
